// file: design/mil_fifo.sv
module mil_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = (AW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic ready_reg;

  wire push = in_valid && ready_reg;
  wire pop = out_valid && out_ready;

  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign in_ready = ready_reg;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      ready_reg <= in_en && (count_next != DEPTH_C);
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

// file: design/mil_loader.sv
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
module mil_loader #(
  parameter int FIFO_DEPTH = 8,
  parameter int DATA_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] fetch_data,
  input wire logic fetch_valid,
  output logic fetch_ready,
  output logic [DATA_W-1:0] fe_data,
  output logic fe_valid,
  output logic fe_last,
  input wire logic fe_ready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mil_pkg::mil_state_type state_reg;
  logic aw_got_reg, w_got_reg, awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg;
  logic [13:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic cache_en_reg;
  logic switch_req_reg;
  logic cmd_full_reg;
  logic [mil_pkg::CMD_SIZE_W-1:0] cmd_size_reg;
  logic cmd_link_reg;
  logic link_reg;
  logic [mil_pkg::CMD_SIZE_W+2:0] words_left_reg;
  logic [mil_pkg::ST_DONE_W-1:0] done_cnt_reg;
  logic [DATA_W-1:0] out_data_reg;
  logic out_valid_reg, out_last_reg;

  // ----------------------------------------------------------------
  // buffer between fetch and front end
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  wire loading = (state_reg == mil_pkg::ST_LOAD);
  wire slot_free = !out_valid_reg || fe_ready;
  wire take = loading && fifo_valid && slot_free;

  mil_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_en(cache_en_reg),
    .in_valid(fetch_valid),
    .in_ready(fetch_ready),
    .in_data(fetch_data),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_do = aw_got_reg && w_got_reg && !bvalid_reg;
  wire wr_cmd = wr_do && (awaddr_reg == mil_pkg::CMD_OFFSET);
  wire wr_switch = wr_do && (awaddr_reg == mil_pkg::SWITCH_OFFSET);
  wire wr_cache = wr_do && (awaddr_reg == mil_pkg::CACHE_CTRL_OFFSET);
  wire wr_status = wr_do && (awaddr_reg == mil_pkg::STATUS_OFFSET);
  wire cmd_ok = wr_cmd && !cmd_full_reg && (wstrb_reg == 4'hF);
  wire wr_err = wr_do && !(cmd_ok || wr_switch || wr_cache || wr_status);
  wire rd_do = s_axi_arvalid && arready_reg;
  wire [31:0] status_word = {16'h0000, done_cnt_reg, 4'h0, link_reg,
                             state_reg == mil_pkg::ST_SWITCHED, cmd_full_reg, loading};
  wire [31:0] cmd_word = {15'h0000, cmd_link_reg, cmd_size_reg};
  wire [31:0] cache_word = {16'h0000, cache_en_reg, 15'h0000};
  wire [31:0] switch_word = {31'h0000_0000, switch_req_reg};
  wire rd_hit_cmd = (s_axi_araddr == mil_pkg::CMD_OFFSET);
  wire rd_hit_st = (s_axi_araddr == mil_pkg::STATUS_OFFSET);
  wire rd_hit_sw = (s_axi_araddr == mil_pkg::SWITCH_OFFSET);
  wire rd_hit_ca = (s_axi_araddr == mil_pkg::CACHE_CTRL_OFFSET);
  wire rd_hit = rd_hit_cmd || rd_hit_st || rd_hit_sw || rd_hit_ca;
  wire [31:0] rd_word = rd_hit_cmd ? cmd_word :
                        rd_hit_st ? status_word :
                        rd_hit_sw ? switch_word :
                        rd_hit_ca ? cache_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // command boundary control
  // ----------------------------------------------------------------
  wire last_take = take && (words_left_reg == 19'h0_0001);
  wire can_switch = switch_req_reg && !link_reg;
  wire start_cmd = cmd_full_reg && !can_switch && (cmd_size_reg != '0);
  wire skip_cmd = cmd_full_reg && !can_switch && (cmd_size_reg == '0);
  wire [mil_pkg::CMD_SIZE_W+2:0] words_start =
    (mil_pkg::CMD_SIZE_W+3)'(cmd_size_reg) * (mil_pkg::CMD_SIZE_W+3)'(mil_pkg::WORDS_PER_UNIT);

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= mil_pkg::RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[13:2], 2'b00};
      end
      if (s_axi_wvalid && wready_reg) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      awready_reg <= !aw_got_reg && !(s_axi_awvalid && awready_reg) && !bvalid_reg && !wr_do;
      wready_reg <= !w_got_reg && !(s_axi_wvalid && wready_reg) && !bvalid_reg && !wr_do;
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_err ? mil_pkg::RESP_SLVERR : mil_pkg::RESP_OKAY;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= mil_pkg::RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_reg && !rd_do;
      if (rd_do) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? mil_pkg::RESP_OKAY : mil_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers and command slot
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cache_en_reg <= mil_pkg::CACHE_EN_RESET;
      switch_req_reg <= 1'b0;
      cmd_full_reg <= 1'b0;
      cmd_size_reg <= '0;
      cmd_link_reg <= 1'b0;
    end else begin
      if (wr_cache && wstrb_reg[1]) begin
        cache_en_reg <= wdata_reg[mil_pkg::CACHE_EN_BIT];
      end
      if (wr_switch && wstrb_reg[0]) begin
        switch_req_reg <= wdata_reg[mil_pkg::SWITCH_REQ_BIT];
      end
      if (cmd_ok) begin
        cmd_full_reg <= 1'b1;
        cmd_size_reg <= wdata_reg[mil_pkg::CMD_SIZE_LSB +: mil_pkg::CMD_SIZE_W];
        cmd_link_reg <= wdata_reg[mil_pkg::CMD_LINK_BIT];
      end else if (state_reg == mil_pkg::ST_IDLE && (start_cmd || skip_cmd)) begin
        cmd_full_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= mil_pkg::ST_IDLE;
      words_left_reg <= '0;
      link_reg <= 1'b0;
      done_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        mil_pkg::ST_IDLE: begin
          if (can_switch) begin
            state_reg <= mil_pkg::ST_SWITCHED;
          end else if (start_cmd || skip_cmd) begin
            link_reg <= cmd_link_reg;
            words_left_reg <= words_start;
            if (start_cmd) begin
              state_reg <= mil_pkg::ST_LOAD;
            end else begin
              done_cnt_reg <= done_cnt_reg + 1'b1;
            end
          end
        end
        mil_pkg::ST_LOAD: begin
          if (take) begin
            words_left_reg <= words_left_reg - 1'b1;
          end
          if (last_take) begin
            state_reg <= mil_pkg::ST_IDLE;
            done_cnt_reg <= done_cnt_reg + 1'b1;
          end
        end
        mil_pkg::ST_SWITCHED: begin
          if (!switch_req_reg) begin
            state_reg <= mil_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // front end output stage
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      out_last_reg <= 1'b0;
    end else if (take) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= fifo_data;
      out_last_reg <= last_take;
    end else if (fe_ready) begin
      out_valid_reg <= 1'b0;
      out_last_reg <= 1'b0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign fe_valid = out_valid_reg;
  assign fe_data = out_data_reg;
  assign fe_last = out_last_reg;

endmodule

// file: design/mil_pkg.sv
package mil_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [13:0] CMD_OFFSET = 14'h0000;
  localparam logic [13:0] STATUS_OFFSET = 14'h0004;
  localparam logic [13:0] SWITCH_OFFSET = 14'h0008;
  localparam logic [13:0] CACHE_CTRL_OFFSET = 14'h2124;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_SIZE_LSB = 0;
  localparam int CMD_SIZE_W = 16;
  localparam int CMD_LINK_BIT = 16;
  localparam int CACHE_EN_BIT = 15;
  localparam int SWITCH_REQ_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_GRANT_BIT = 2;
  localparam int ST_LINK_BIT = 3;
  localparam int ST_DONE_LSB = 8;
  localparam int ST_DONE_W = 8;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic CACHE_EN_RESET = 1'b0;
  localparam int UNIT_BYTES = 32;
  localparam int WORD_BYTES = 4;
  localparam int WORDS_PER_UNIT = UNIT_BYTES / WORD_BYTES;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SWITCHED = 2'b10
  } mil_state_type;

endpackage

// file: tb/mil_fetch_model.sv
module mil_fetch_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [31:0] fetch_data,
  output logic fetch_valid,
  input wire logic fetch_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words[$];
  always @(posedge aclk) begin
    if (!aresetn) begin
      fetch_valid <= 1'b0;
      fetch_data <= 32'h0000_0000;
    end else if (fetch_valid && !fetch_ready) begin
      fetch_valid <= 1'b1;
    end else if (words.size() > 0 && $urandom_range(3) != 0) begin
      fetch_valid <= 1'b1;
      fetch_data <= words.pop_front();
    end else begin
      fetch_valid <= 1'b0;
      fetch_data <= ~fetch_data;
    end
  end
endmodule

// file: tb/mil_loader_assertions.sv
module mil_loader_assertions #(
  parameter int DATA_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] fe_data,
  input wire logic fe_valid,
  input wire logic fe_last,
  input wire logic fe_ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  fe_hold_a: assert property (fe_valid && !fe_ready |=> fe_valid && $stable(fe_data) && $stable(fe_last))
    else $error("front end word changed while stalled");
  last_qual_a: assert property (fe_last |-> fe_valid)
    else $error("last marker without valid word");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
endmodule

bind mil_loader mil_loader_assertions #(.DATA_W(DATA_W)) i_mil_loader_assertions (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .fe_data(fe_data), .fe_valid(fe_valid), .fe_last(fe_last), .fe_ready(fe_ready));

// file: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, fe_ready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, fetch_valid, fetch_ready, fe_valid, fe_last;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, fetch_data, fe_data, rd;
  logic [33:0] exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;
  always #4 aclk = ~aclk;

  mil_loader #(.FIFO_DEPTH(8), .DATA_W(32)) i_mil_loader (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fetch_data(fetch_data), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
    .fe_data(fe_data), .fe_valid(fe_valid), .fe_last(fe_last), .fe_ready(fe_ready));
  mil_fetch_model i_mil_fetch_model (.aclk(aclk), .aresetn(aresetn), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [13:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic poll_st(input logic [31:0] mask, input logic [31:0] val);
    for (int k = 0; k < 100; k++) begin
      axi_rd(mil_pkg::STATUS_OFFSET);
      if ((rd & mask) === val) break;
    end
    chk("status", {2'b00, val}, {2'b00, rd & mask});
  endtask
  task automatic load(input int units);
    logic [31:0] w;
    for (int k = 0; k < units * mil_pkg::WORDS_PER_UNIT; k++) begin
      w = $urandom;
      i_mil_fetch_model.words.push_back(w);
      exp_q.push_back({1'b0, k == units * mil_pkg::WORDS_PER_UNIT - 1, w});
    end
  endtask

  // ----------------------------------------------------------------
  // front end monitor
  // ----------------------------------------------------------------
  always @(posedge aclk) fe_ready <= ($urandom_range(3) != 0);
  always @(posedge aclk) begin
    if (fe_valid && fe_ready) begin
      if (exp_q.size() == 0) chk("fe extra", 34'h0_0000_0000, {2'b11, fe_last, fe_data});
      else chk("fe word", exp_q.pop_front(), {1'b0, fe_last, fe_data});
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(5284));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(14'h0100);
    chk("unmapped read", {mil_pkg::RESP_SLVERR, 32'h0000_0000}, {rsp, rd});
    axi_rd(mil_pkg::CACHE_CTRL_OFFSET);
    chk("cache reset", {mil_pkg::RESP_OKAY, 32'h0000_0000}, {rsp, rd});
    axi_wr(mil_pkg::CMD_OFFSET, 32'h0000_0001, 4'h3);
    chk("cmd strobe", {32'h0000_0000, mil_pkg::RESP_SLVERR}, {32'h0000_0000, rsp});
    axi_wr(14'h0100, 32'h0000_0001, 4'hf);
    chk("unmapped write", {32'h0000_0000, mil_pkg::RESP_SLVERR}, {32'h0000_0000, rsp});
    axi_wr(mil_pkg::STATUS_OFFSET, 32'hffff_ffff, 4'hf);
    chk("status write", {32'h0000_0000, mil_pkg::RESP_OKAY}, {32'h0000_0000, rsp});
    poll_st(32'hffff_ffff, 32'h0000_0000);
    $display("test registers done");
    load(1);
    load(2);
    repeat (30) @(posedge aclk);
    chk("fetch gated", 34'h0_0000_0000, {33'h0_0000_0000, fetch_ready});
    axi_wr(mil_pkg::CACHE_CTRL_OFFSET, 32'h0000_8000, 4'hf);
    repeat (30) @(posedge aclk);
    chk("fifo full", 34'h0_0000_0000, {33'h0_0000_0000, fetch_ready});
    axi_wr(mil_pkg::CMD_OFFSET, 32'h0000_0001, 4'hf);
    poll_st(32'h0000_0002, 32'h0000_0000);
    axi_wr(mil_pkg::CMD_OFFSET, 32'h0000_0002, 4'hf);
    poll_st(32'h0000_ff03, 32'h0000_0200);
    // let the last held word drain before counting leftovers
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    chk("words left", 34'h0_0000_0000, 34'(exp_q.size()));
    $display("test stream done");
    axi_wr(mil_pkg::SWITCH_OFFSET, 32'h0000_0001, 4'hf);
    poll_st(32'h0000_0004, 32'h0000_0004);
    axi_wr(mil_pkg::CMD_OFFSET, 32'h0001_0000, 4'hf);
    repeat (20) @(posedge aclk);
    poll_st(32'h0000_ff06, 32'h0000_0206);
    axi_wr(mil_pkg::SWITCH_OFFSET, 32'h0000_0000, 4'hf);
    poll_st(32'h0000_ff00, 32'h0000_0300);
    axi_wr(mil_pkg::SWITCH_OFFSET, 32'h0000_0001, 4'hf);
    repeat (20) @(posedge aclk);
    poll_st(32'h0000_ff0c, 32'h0000_0308);
    axi_wr(mil_pkg::CMD_OFFSET, 32'h0000_0000, 4'hf);
    poll_st(32'h0000_ff04, 32'h0000_0404);
    axi_wr(mil_pkg::SWITCH_OFFSET, 32'h0000_0000, 4'hf);
    $display("test switch done");
    wrap_up();
  end
endmodule
